// >>> dv/pci_far_side.sv
/*
  Far side of the arbiter: bus idle, flush responder, south bridge hold.
  Assumes callers of its tasks sit just after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module pci_far_side #(
  parameter int SLOW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Flush handshake
  input wire logic flush_coh,
  input wire logic flush_wb,
  output logic flush_done,
  // Bus and hold
  output logic bus_idle,
  output logic hold_req_n
);
  int cnt;

  // Idle bus lets slices count at once
  initial
  begin
    bus_idle = 1'b1;
    hold_req_n = 1'b1;
  end

  // Slow answer, so a grant must wait for it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      flush_done <= 1'b0;
    end
    else
    begin
      cnt <= (flush_coh | flush_wb) ? cnt + 1 : 0;
      flush_done <= (flush_coh | flush_wb) && cnt >= SLOW;
    end
  end

  task sb_hold(input logic on);
    @(posedge clk);
    hold_req_n <= !on;
  endtask : sb_hold

  // Called just after an edge; the bench chooses how long the bus stays busy
  task set_idle(input logic on);
    bus_idle <= on;
  endtask : set_idle

  task pattern;
    @(posedge clk);
    hold_req_n <= 1'b1;
    @(posedge clk);
    hold_req_n <= 1'b0;
  endtask : pattern
endmodule : pci_far_side
`default_nettype wire

// >>> dv/pci_master_arbiter_options_bench.sv
/*
  Bench: registers, options, slices, retry limits, passive release, flush.
  Assumes pci_far_side models the bus, the flush logic and south bridge.
*/
`timescale 1ns/1ps
`default_nettype none

module pci_master_arbiter_options_bench;
  import arb_opt_pkg::*;
  logic clk, rst_n, psel, pen, pwr, cpu_req, lock_n, mcyc, mrd, mrdy, rdy, err, e;
  logic cpu_gnt, hgnt_n, prel, lock_h, fc, fw, fd, idle, hreq_n, retry, cfg, bw, br, pf;
  logic [11:0] pa;
  logic [31:0] pwd, prd, r;
  logic [3:0] pbuf;
  logic [4:0] mreq, mgnt;
  logic [7:0] v;
  logic [31:0] seed = 32'hc151;
  int bad_count, n_checks, n;
  int rst_q[$] = '{0, 'h20, 'h20, 0, 0, 0};
  int lim1[$] = '{32, 16, 8, 40};
  int lim2[$] = '{8, 4, 2, 40};

  pci_arbiter_options pci_arbiter_options_inst (.CLK_SYS(clk), .RESETN(rst_n),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(rdy), .PSLVERR(err), .CPU_REQ(cpu_req), .CPU_GNT(cpu_gnt), .MST_REQ(mreq),
    .MST_GNT(mgnt), .SOUTHBRIDGE_HOLD_REQUEST_N(hreq_n), .SOUTHBRIDGE_HOLD_GRANT_N(hgnt_n),
    .PASSIVE_RELEASE(prel), .BUS_IDLE(idle), .MASTER_LOCK_INPUT_N(lock_n),
    .LOCK_HONOURED(lock_h), .FLUSH_COHERENT_REQ(fc), .FLUSH_WRITE_BUFFER_REQ(fw),
    .FLUSH_DONE(fd), .MST_CYCLE(mcyc), .MST_READ(mrd), .MST_DATA_RDY(mrdy),
    .MST_RETRY(retry), .CFG_ACCESS_EN(cfg), .BURST_WRITE_EN(bw), .BURST_READ_EN(br),
    .PREFETCH_EN(pf), .PREFETCH_BUFFERS(pbuf));

  pci_far_side pci_far_side_inst (.clk(clk), .rst_n(rst_n), .flush_coh(fc),
    .flush_wb(fw), .flush_done(fd), .bus_idle(idle), .hold_req_n(hreq_n));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    r = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  // Waits to a retry; 40 means none came
  task meas(input logic first);
    @(posedge clk);
    mcyc <= 1'b1;
    mrdy <= !first;
    @(posedge clk);
    mrdy <= 1'b0;
    n = 0;
    while (retry !== 1'b1 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    mcyc <= 1'b0;
  endtask : meas

  task end_of_test;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    {rst_n, psel, pen, pwr, cpu_req, mcyc, mrdy, pa, pwd, mreq} = '0;
    {lock_n, mrd} = 2'b11;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb(0, ADDR_ARB_OPT + 12'(4 * i), 0);
      chk(r, rst_q[i]);
    end
    chk({cfg, bw, br, pf, pbuf}, 8'h71);
    apb(0, 12'h238, 0);
    chk(e, 1);
    apb(1, ADDR_MST_SLICE, 8'h0b);
    apb(0, ADDR_MST_SLICE, 0);
    chk(r, 32'h08);
    for (int i = 0; i < 9; i++)
    begin
      v = 8'(xs());
      v[3:0] = {i == 8, 3'(i)};
      apb(1, ADDR_MEM_OPT, v);
      repeat (2) @(posedge clk);
      chk({cfg, bw, br, pf}, {v[6], ~v[5:3]});
      chk(pbuf, v[3] ? 0 : v[2:0] + 4'h1);
    end
    mreq <= 5'h02;
    while (mgnt !== 5'h02) @(posedge clk);
    mreq <= 5'h06;
    pci_far_side_inst.set_idle(1'b0);
    n = 0;
    while (mgnt === 5'h02 && n < 40)
    begin
      @(posedge clk);
      n++;
      if (n == 4)
        pci_far_side_inst.set_idle(1'b1);
    end
    chk(n >= 12 && n <= 16, 1);
    n = 0;
    while (mgnt !== 5'h04 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    chk(mgnt, 5'h04);
    mreq <= 5'h01;
    while (mgnt !== 5'h01) @(posedge clk);
    for (int c = 0; c < 4; c++)
    begin
      apb(1, ADDR_RETRY_CTL, 8'(c * 5));
      meas(1);
      chk(n >= lim1[c] && n <= lim1[c] + 3, 1);
      meas(0);
      chk(n >= lim2[c] && n <= lim2[c] + 3, 1);
    end
    mreq <= 5'h00;
    pci_far_side_inst.sb_hold(1);
    while (hgnt_n !== 1'b0) @(posedge clk);
    pci_far_side_inst.pattern();
    repeat (4) @(posedge clk);
    chk({hgnt_n, prel}, 2'b00);
    apb(1, ADDR_ARB_OPT, 8'h02);
    cpu_req <= 1'b1;
    pci_far_side_inst.pattern();
    repeat (2) @(posedge clk);
    chk({hgnt_n, prel}, 2'b11);
    chk(cpu_gnt, 0);
    repeat (2) @(posedge clk);
    chk({cpu_gnt, hgnt_n}, 2'b00);
    pci_far_side_inst.sb_hold(0);
    n = 0;
    while (cpu_gnt !== 1'b1 && n < 12)
    begin
      @(posedge clk);
      n++;
    end
    chk({cpu_gnt, prel}, 2'b10);
    cpu_req <= 1'b0;
    apb(1, ADDR_ARB_OPT, 8'h08);
    mreq <= 5'h08;
    while (fc !== 1'b1) @(posedge clk);
    chk({fw, mgnt}, 6'h20);
    while (mgnt !== 5'h08) @(posedge clk);
    chk(fc, 0);
    lock_n <= 1'b0;
    mreq <= 5'h0c;
    repeat (40) @(posedge clk);
    chk({lock_h, mgnt}, 6'h28);
    apb(1, ADDR_ARB_OPT, 8'h18);
    repeat (2) @(posedge clk);
    chk(lock_h, 0);
    end_of_test();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule : pci_master_arbiter_options_bench
`default_nettype wire

// >>> rtl/arb_opt_pkg.sv
/*
  Constants for the PCI arbiter and PCI-to-memory option block.
  Assumes a 12-bit APB byte address, one register per 32-bit word.
*/
package arb_opt_pkg;
  localparam int NUM_MST = 5;
  localparam int NUM_REQ = 7;
  localparam int APB_AW = 12;
  localparam logic [7:0] IDX_ARB_OPT = 8'h88;
  localparam logic [7:0] IDX_MST_SLICE = 8'h89;
  localparam logic [7:0] IDX_CPU_SLICE = 8'h8a;
  localparam logic [7:0] IDX_RETRY_CTL = 8'h8b;
  localparam logic [7:0] IDX_MEM_OPT = 8'h8c;
  localparam logic [7:0] IDX_CLK_CTL = 8'h8d;
  localparam logic [7:0] IDX_STATUS = 8'hc0;
  localparam logic [11:0] ADDR_ARB_OPT = {2'h0, IDX_ARB_OPT, 2'h0};
  localparam logic [11:0] ADDR_MST_SLICE = {2'h0, IDX_MST_SLICE, 2'h0};
  localparam logic [11:0] ADDR_CPU_SLICE = {2'h0, IDX_CPU_SLICE, 2'h0};
  localparam logic [11:0] ADDR_RETRY_CTL = {2'h0, IDX_RETRY_CTL, 2'h0};
  localparam logic [11:0] ADDR_MEM_OPT = {2'h0, IDX_MEM_OPT, 2'h0};
  localparam logic [11:0] ADDR_CLK_CTL = {2'h0, IDX_CLK_CTL, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam int ARB_RETRY_MARK = 7;
  localparam int ARB_LOCK_ARB_N = 6;
  localparam int ARB_FLUSH_N = 5;
  localparam int ARB_LOCK_REC_N = 4;
  localparam int ARB_FORCE_FLUSH = 3;
  localparam int ARB_CPU_PR = 2;
  localparam int ARB_PR_EN = 1;
  localparam int ARB_ISA_GUAR = 0;
  localparam int RC_SCALE = 4;
  localparam int RC_LAT2 = 2;
  localparam int RC_LAT1 = 0;
  localparam int MO_NONPRE = 7;
  localparam int MO_CFG = 6;
  localparam int MO_BWR_N = 5;
  localparam int MO_BRD_N = 4;
  localparam int MO_PF_N = 3;
  localparam int MO_PF_TH = 0;
  localparam logic [7:0] RST_ARB_OPT = 8'h00;
  localparam logic [7:0] RST_SLICE = 8'h20;
  localparam logic [7:0] RST_RETRY_CTL = 8'h00;
  localparam logic [7:0] RST_MEM_OPT = 8'h00;
  localparam logic [7:0] RST_CLK_CTL = 8'h00;
  localparam logic [5:0] LAT1_C0 = 6'h20;
  localparam logic [5:0] LAT1_C1 = 6'h10;
  localparam logic [5:0] LAT1_C2 = 6'h08;
  localparam logic [5:0] LAT2_C0 = 6'h08;
  localparam logic [5:0] LAT2_C1 = 6'h04;
  localparam logic [5:0] LAT2_C2 = 6'h02;
  localparam logic [2:0] OWN_MST0 = 3'h0;
  localparam logic [2:0] OWN_SB = 3'h5;
  localparam logic [2:0] OWN_CPU = 3'h6;
  typedef enum logic [1:0] {ST_IDLE, ST_FLUSH, ST_GRANT, ST_OWN} arb_state_t;
endpackage : arb_opt_pkg

// >>> rtl/pci_arbiter_options.sv
/*
  PCI arbiter with PCI-to-memory options: APB registers, flush before
  grant, lock, passive release, time slices and retry latency limits.
  Assumes CLK_SYS is the PCI clock and every input is synchronous to it.
*/
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module pci_arbiter_options (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [arb_opt_pkg::APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Requests and grants
  input wire logic CPU_REQ,
  output logic CPU_GNT,
  input wire logic [arb_opt_pkg::NUM_MST-1:0] MST_REQ,
  output logic [arb_opt_pkg::NUM_MST-1:0] MST_GNT,
  input wire logic SOUTHBRIDGE_HOLD_REQUEST_N,
  output logic SOUTHBRIDGE_HOLD_GRANT_N,
  output logic PASSIVE_RELEASE,
  // Bus state and lock
  input wire logic BUS_IDLE,
  input wire logic MASTER_LOCK_INPUT_N,
  output logic LOCK_HONOURED,
  // Buffer flush
  output logic FLUSH_COHERENT_REQ,
  output logic FLUSH_WRITE_BUFFER_REQ,
  input wire logic FLUSH_DONE,
  // Master memory cycle
  input wire logic MST_CYCLE,
  input wire logic MST_READ,
  input wire logic MST_DATA_RDY,
  output logic MST_RETRY,
  // Memory path options
  output logic CFG_ACCESS_EN,
  output logic BURST_WRITE_EN,
  output logic BURST_READ_EN,
  output logic PREFETCH_EN,
  output logic [3:0] PREFETCH_BUFFERS
);
  import arb_opt_pkg::*;

  logic [7:0] opt_q;
  logic [7:0] mslice_q;
  logic [7:0] cslice_q;
  logic [7:0] rc_q;
  logic [7:0] mopt_q;
  logic [7:0] clkc_q;
  logic setup;
  logic wr_en;
  logic hit;
  logic [31:0] rdata;
  logic [15:0] status;
  arb_state_t state_q;
  logic [2:0] owner_q;
  logic [2:0] last_q;
  logic [2:0] pick;
  logic pick_ok;
  int j;
  logic [NUM_REQ-1:0] req_raw;
  logic [NUM_REQ-1:0] elig;
  logic [NUM_REQ-1:0] others;
  logic [NUM_REQ-1:0] mark_q;
  logic [NUM_REQ-1:0] mark_set;
  logic [NUM_REQ-1:0] mark_clr;
  logic [1:0] sbh_q;
  logic sb_req;
  logic lock_act;
  logic own_mst;
  logic pick_pci;
  logic mark_pick;
  logic need_coh;
  logic need_wb;
  logic pr_hit;
  logic own_drop;
  logic preempt;
  logic slice_exp;
  logic restart_q;
  logic mst_exp;
  logic cpu_exp;
  logic [1:0] shift;
  logic [7:0] m_val;
  logic [7:0] c_val;
  logic [5:0] wcnt_q;
  logic [1:0] phase_q;
  logic [5:0] lim;
  logic never;
  logic retry_now;

  // APB: no wait states, the answer lands in the first access cycle
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PREADY & PWRITE;
  assign status = {2'h0, FLUSH_WRITE_BUFFER_REQ, FLUSH_COHERENT_REQ,
                   PASSIVE_RELEASE, lock_act, 2'(state_q), owner_q,
                   mark_q[NUM_MST-1:0]};

  always_comb
  begin
    hit = 1'b1;
    rdata = 32'h0;
    case (PADDR)
      ADDR_ARB_OPT: rdata = {24'h0, opt_q};
      ADDR_MST_SLICE: rdata = {24'h0, mslice_q};
      ADDR_CPU_SLICE: rdata = {24'h0, cslice_q};
      ADDR_RETRY_CTL: rdata = {24'h0, rc_q};
      ADDR_MEM_OPT: rdata = {24'h0, mopt_q};
      ADDR_CLK_CTL: rdata = {24'h0, clkc_q};
      ADDR_STATUS: rdata = {16'h0, status};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end
    else
    begin
      PREADY <= setup;
      PSLVERR <= setup & ~hit;
      PRDATA <= (setup & ~PWRITE) ? rdata : 32'h0;
    end
  end

  // Register writes; status is read-only
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      opt_q <= RST_ARB_OPT;
      mslice_q <= RST_SLICE;
      cslice_q <= RST_SLICE;
      rc_q <= RST_RETRY_CTL;
      mopt_q <= RST_MEM_OPT;
      clkc_q <= RST_CLK_CTL;
    end
    else if (wr_en)
    begin
      if (PADDR == ADDR_ARB_OPT)
        opt_q <= PWDATA[7:0];
      if (PADDR == ADDR_MST_SLICE)
        mslice_q <= {PWDATA[7:2], 2'h0};
      if (PADDR == ADDR_CPU_SLICE)
        cslice_q <= {PWDATA[7:2], 2'h0};
      if (PADDR == ADDR_RETRY_CTL)
        rc_q <= {2'h0, PWDATA[5:0]};
      if (PADDR == ADDR_MEM_OPT)
        mopt_q <= PWDATA[7:0];
      if (PADDR == ADDR_CLK_CTL)
        clkc_q <= PWDATA[7:0];
    end
  end

  // Requester vector: masters 0-4, south bridge 5, CPU path 6
  assign sb_req = ~SOUTHBRIDGE_HOLD_REQUEST_N;
  assign lock_act = ~opt_q[ARB_LOCK_REC_N] & ~MASTER_LOCK_INPUT_N;
  assign req_raw = {CPU_REQ, sb_req, MST_REQ};
  assign elig = {CPU_REQ & (~PASSIVE_RELEASE | opt_q[ARB_CPU_PR]),
                 sb_req & ~PASSIVE_RELEASE, MST_REQ};
  assign others = elig & ~(7'h01 << owner_q);
  assign own_mst = owner_q < OWN_SB;

  // Round robin starting after the last owner
  always_comb
  begin
    j = 0;
    pick_ok = 1'b0;
    pick = last_q;
    for (int k = 1; k <= NUM_REQ; k++)
    begin
      j = (int'(last_q) + k) % NUM_REQ;
      if (!pick_ok && elig[j])
      begin
        pick_ok = 1'b1;
        pick = 3'(j);
      end
    end
  end

  // The CPU path never needs flushing before its own grant
  assign pick_pci = pick != OWN_CPU;
  assign mark_pick = pick_pci & mark_q[pick] & opt_q[ARB_RETRY_MARK];
  assign need_coh = pick_pci & (mark_pick | opt_q[ARB_FORCE_FLUSH]);
  assign need_wb = pick_pci & (opt_q[ARB_FORCE_FLUSH]
                   | (mark_pick & ~opt_q[ARB_FLUSH_N] & opt_q[ARB_ISA_GUAR]));

  // A one-clock blip of the hold request is a passive release, not a drop
  assign pr_hit = (owner_q == OWN_SB) & opt_q[ARB_PR_EN]
                  & sbh_q[1] & ~sbh_q[0] & sb_req;
  assign own_drop = (owner_q == OWN_SB) ? (~sb_req & ~sbh_q[0]) : ~req_raw[owner_q];
  assign slice_exp = (own_mst & mst_exp) | ((owner_q == OWN_CPU) & cpu_exp);
  assign preempt = slice_exp & (|others)
                   & ~(lock_act & ~opt_q[ARB_LOCK_ARB_N])
                   & ~(mopt_q[MO_NONPRE] & (owner_q == OWN_MST0));

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
      sbh_q <= 2'h0;
    else
      sbh_q <= {sbh_q[0], sb_req};
  end

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_q <= ST_IDLE;
      owner_q <= OWN_CPU;
      last_q <= OWN_CPU;
      CPU_GNT <= 1'b0;
      MST_GNT <= 5'h00;
      SOUTHBRIDGE_HOLD_GRANT_N <= 1'b1;
      FLUSH_COHERENT_REQ <= 1'b0;
      FLUSH_WRITE_BUFFER_REQ <= 1'b0;
      PASSIVE_RELEASE <= 1'b0;
      restart_q <= 1'b0;
    end
    else
    begin
      restart_q <= 1'b0;
      unique case (state_q)
        ST_IDLE:
          if (pick_ok)
          begin
            owner_q <= pick;
            if (need_coh | need_wb)
            begin
              FLUSH_COHERENT_REQ <= need_coh;
              FLUSH_WRITE_BUFFER_REQ <= need_wb;
              state_q <= ST_FLUSH;
            end
            else
              state_q <= ST_GRANT;
          end
          else if (PASSIVE_RELEASE & sb_req)
          begin
            // No other requester is eligible: hand it back to the south bridge
            owner_q <= OWN_SB;
            PASSIVE_RELEASE <= 1'b0;
            state_q <= ST_GRANT;
          end
        ST_FLUSH:
          if (FLUSH_DONE)
          begin
            FLUSH_COHERENT_REQ <= 1'b0;
            FLUSH_WRITE_BUFFER_REQ <= 1'b0;
            state_q <= ST_GRANT;
          end
        ST_GRANT:
        begin
          CPU_GNT <= owner_q == OWN_CPU;
          MST_GNT <= own_mst ? (5'h01 << owner_q) : 5'h00;
          SOUTHBRIDGE_HOLD_GRANT_N <= owner_q != OWN_SB;
          restart_q <= 1'b1;
          state_q <= ST_OWN;
        end
        ST_OWN:
          if (own_drop | pr_hit | (preempt & (owner_q != OWN_SB)))
          begin
            CPU_GNT <= 1'b0;
            MST_GNT <= 5'h00;
            SOUTHBRIDGE_HOLD_GRANT_N <= 1'b1;
            last_q <= owner_q;
            state_q <= ST_IDLE;
            if (pr_hit)
              PASSIVE_RELEASE <= 1'b1;
          end
      endcase
    end
  end

  // Retry marks: a mark set in the cycle it is consumed survives
  assign mark_clr = (state_q == ST_GRANT) ? (7'h01 << owner_q) : 7'h00;
  assign mark_set = (retry_now & MST_READ & own_mst & opt_q[ARB_RETRY_MARK])
                    ? (7'h01 << owner_q) : 7'h00;

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
      mark_q <= 7'h00;
    else
      mark_q <= (mark_q & ~mark_clr) | mark_set;
  end

  // Slice scaling during passive release
  always_comb
  begin
    unique case (rc_q[RC_SCALE +: 2])
      2'b00: shift = 2'd1;
      2'b01: shift = 2'd2;
      2'b10: shift = 2'd3;
      2'b11: shift = 2'd0;
    endcase
  end

  assign m_val = PASSIVE_RELEASE ? (mslice_q >> shift) : mslice_q;
  assign c_val = PASSIVE_RELEASE ? (cslice_q >> shift) : cslice_q;

  slice_timer u_mst_slice (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .restart(restart_q),
    .active((state_q == ST_OWN) & own_mst),
    .idle(BUS_IDLE),
    .slice(m_val),
    .expired(mst_exp)
  );

  slice_timer u_cpu_slice (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .restart(restart_q),
    .active((state_q == ST_OWN) & (owner_q == OWN_CPU)),
    .idle(BUS_IDLE),
    .slice(c_val),
    .expired(cpu_exp)
  );

  // Retry latency limits; wait count equal to the limit means one more exceeds it
  always_comb
  begin
    lim = LAT1_C0;
    never = 1'b0;
    if (phase_q == 2'd0)
    begin
      unique case (rc_q[RC_LAT1 +: 2])
        2'b00: lim = LAT1_C0;
        2'b01: lim = LAT1_C1;
        2'b10: lim = LAT1_C2;
        2'b11: never = 1'b1;
      endcase
    end
    else if (phase_q == 2'd1)
    begin
      unique case (rc_q[RC_LAT2 +: 2])
        2'b00: lim = LAT2_C0;
        2'b01: lim = LAT2_C1;
        2'b10: lim = LAT2_C2;
        2'b11: never = 1'b1;
      endcase
    end
    else
      never = 1'b1;
  end

  assign retry_now = MST_CYCLE & ~MST_DATA_RDY & ~never & (wcnt_q == lim);

  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      wcnt_q <= 6'h00;
      phase_q <= 2'd0;
      MST_RETRY <= 1'b0;
    end
    else
    begin
      MST_RETRY <= retry_now;
      if (!MST_CYCLE || retry_now)
      begin
        wcnt_q <= 6'h00;
        phase_q <= 2'd0;
      end
      else if (MST_DATA_RDY)
      begin
        wcnt_q <= 6'h00;
        if (phase_q != 2'd2)
          phase_q <= phase_q + 2'd1;
      end
      else if (wcnt_q != 6'h3f)
        wcnt_q <= wcnt_q + 6'h01;
    end
  end

  // Memory path option outputs and the lock honoured flag
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      CFG_ACCESS_EN <= 1'b0;
      BURST_WRITE_EN <= 1'b1;
      BURST_READ_EN <= 1'b1;
      PREFETCH_EN <= 1'b1;
      PREFETCH_BUFFERS <= 4'h1;
      LOCK_HONOURED <= 1'b0;
    end
    else
    begin
      CFG_ACCESS_EN <= mopt_q[MO_CFG];
      BURST_WRITE_EN <= ~mopt_q[MO_BWR_N];
      BURST_READ_EN <= ~mopt_q[MO_BRD_N];
      PREFETCH_EN <= ~mopt_q[MO_PF_N];
      PREFETCH_BUFFERS <= mopt_q[MO_PF_N] ? 4'h0
                          : ({1'b0, mopt_q[MO_PF_TH +: 3]} + 4'h1);
      LOCK_HONOURED <= lock_act;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  a_slice_write_low: assert property (wr_en && PADDR == ADDR_MST_SLICE
    |=> mslice_q == {$past(PWDATA[7:2]), 2'h0})
    else $error("Slice low bits not forced to zero");
  a_hold_kept: assert property (!opt_q[ARB_PR_EN] && !SOUTHBRIDGE_HOLD_GRANT_N
    && sb_req |=> !SOUTHBRIDGE_HOLD_GRANT_N)
    else $error("Hold grant dropped with recognition off");
  a_pr_release: assert property (state_q == ST_OWN && pr_hit
    |=> SOUTHBRIDGE_HOLD_GRANT_N && PASSIVE_RELEASE && state_q == ST_IDLE)
    else $error("Passive release not honoured");
  a_lock_holds: assert property (state_q == ST_OWN && lock_act
    && !opt_q[ARB_LOCK_ARB_N] && !own_drop |=> state_q == ST_OWN)
    else $error("Re-arbitrated during locked transaction");
  a_force_flush: assert property (state_q == ST_IDLE && pick_ok && pick_pci
    && opt_q[ARB_FORCE_FLUSH] |=> state_q == ST_FLUSH && FLUSH_COHERENT_REQ
    ##1 (MST_GNT == 5'h00 && SOUTHBRIDGE_HOLD_GRANT_N))
    else $error("Master granted without forced flush");
  a_cpu_pr_block: assert property (PASSIVE_RELEASE && !opt_q[ARB_CPU_PR]
    |-> !(state_q == ST_IDLE && pick_ok && pick == OWN_CPU))
    else $error("CPU chosen during passive release");
  a_retry_first: assert property (MST_RETRY && $past(phase_q) == 2'd0
    && $past(rc_q) == 8'h00 |-> $past(wcnt_q) == 6'h20)
    else $error("First phase retry at wrong wait count");
  a_retry_second: assert property (MST_RETRY && $past(phase_q) == 2'd1
    && $past(rc_q[RC_LAT2 +: 2]) == 2'b01 |-> $past(wcnt_q) == 6'h04)
    else $error("Second phase retry at wrong wait count");
  a_preempt_end: assert property (state_q == ST_OWN && preempt && owner_q != OWN_SB
    |=> state_q == ST_IDLE && !CPU_GNT && MST_GNT == 5'h00)
    else $error("Expired owner kept the bus");
  a_prefetch_range: assert property (PREFETCH_EN |-> PREFETCH_BUFFERS inside {[1:8]})
    else $error("Prefetch buffer count out of range");
  a_apb_ready: assert property (setup |=> PREADY ##1 !PREADY)
    else $error("APB ready not a single access cycle");
endmodule : pci_arbiter_options

`default_nettype wire

// >>> rtl/slice_timer.sv
/*
  Time-slice counter for one class of bus owner.
  Assumes restart pulses in the first cycle of a grant.
*/
`timescale 1ns/1ps
`default_nettype none

module slice_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic restart,
  input wire logic active,
  input wire logic idle,
  input wire logic [7:0] slice,
  // Result
  output logic expired
);
  logic armed_q;
  logic run_q;
  logic [7:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_q <= 1'b0;
      run_q <= 1'b0;
      cnt_q <= 8'h00;
      expired <= 1'b0;
    end
    else if (!active)
    begin
      armed_q <= 1'b0;
      run_q <= 1'b0;
      expired <= 1'b0;
    end
    else if (restart)
    begin
      armed_q <= 1'b1;
      run_q <= 1'b0;
      cnt_q <= slice;
      expired <= 1'b0;
    end
    else if (armed_q && idle)
    begin
      armed_q <= 1'b0;
      run_q <= 1'b1;
    end
    else if (run_q)
    begin
      if (cnt_q == 8'h00)
        expired <= 1'b1;
      else
        cnt_q <= cnt_q - 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_slice_wait_idle: assert property (armed_q && !idle && !restart && active |=> !run_q)
    else $error("Slice counter started while bus busy");
  a_slice_not_early: assert property (run_q && cnt_q != 8'h00 && active |=> !expired)
    else $error("Slice expired before count ran out");
endmodule : slice_timer

`default_nettype wire
